// file: design/dss_params.svh
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH
`define DSS_IDX_STATUS 16'h6041
`define DSS_IDX_SHUTDOWN 16'h605b
`define DSS_IDX_DISABLE_OP 16'h605c
`define DSS_SHUTDOWN_RST 16'h0000
`define DSS_DISABLE_OP_RST 16'h0001
`define DSS_OPT_COAST 16'h0000
`define DSS_OPT_RAMP 16'h0001
`define DSS_BIT_RTSO 0
`define DSS_BIT_SWON 1
`define DSS_BIT_OPEN 2
`define DSS_BIT_FAULT 3
`define DSS_BIT_VDIS 4
`define DSS_BIT_QSTOP 5
`define DSS_BIT_SODIS 6
`define DSS_BIT_REMOTE 9
`define DSS_BIT_TARGET 10
`define DSS_BIT_ILIM 11
`define DSS_CW_AUTO 11
`define DSS_DCW_AUTO 7
`endif

// file: design/dss_pkg.sv
package dss_pkg;
    typedef enum logic [2:0] {
        DSS_NOT_READY = 3'h0,
        DSS_SO_DISABLED = 3'h1,
        DSS_READY = 3'h3,
        DSS_SWITCHED_ON = 3'h2,
        DSS_OP_ENABLED = 3'h6,
        DSS_QSTOP_ACTIVE = 3'h7,
        DSS_FAULT_REACT = 3'h5,
        DSS_FAULT = 3'h4
    } dss_state_t;
    typedef enum logic [1:0] {
        DSS_STOP_COAST = 2'h0,
        DSS_STOP_RAMP = 2'h1
    } dss_stop_t;
    typedef struct packed {
        logic [1:0] flag_s1;
        logic [1:0] flag_s2;
        logic [15:0] status;
        logic [15:0] shutdown_code;
        logic [15:0] disable_code;
        logic [15:0] rdata;
        logic ack;
        logic err;
        logic auto_bit;
    } dss_regs_t;
endpackage

// file: design/dss_top.sv
`timescale 1ns/100ps
`include "dss_params.svh"
module dss_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic od_req_in,
    input wire logic od_write_in,
    input wire logic [15:0] od_index_in,
    input wire logic [15:0] od_wdata_in,
    output logic od_ack_out,
    output logic od_err_out,
    output logic [15:0] od_rdata_out,
    input wire dss_pkg::dss_state_t dev_state_in,
    input wire logic volt_disable_cmd_in,
    input wire logic [15:0] control_word_in,
    input wire logic control_word_enable_setting_in,
    input wire logic at_speed_flag_in,
    input wire logic drive_running_flag_in,
    input wire logic signed [15:0] vel_demand_in,
    input wire logic [15:0] vel_min_amount_in,
    input wire logic [15:0] vel_max_amount_in,
    output logic [15:0] status_word_out,
    output logic drive_control_word_auto_out,
    output dss_pkg::dss_stop_t shutdown_stop_mode_out,
    output dss_pkg::dss_stop_t disable_op_stop_mode_out,
    output logic slow_down_ramp_sel_out
);
    import dss_pkg::*;

    dss_regs_t r_r;
    dss_regs_t r_nxt;
    logic [15:0] st_bits;
    logic [15:0] vel_abs;
    logic code_ok;
    logic below_min;
    logic above_max;

    function automatic logic [15:0] dss_abs(input logic signed [15:0] v);
        if (v[15]) begin
            dss_abs = 16'(-v);
        end else begin
            dss_abs = 16'(v);
        end
    endfunction

    // only the ramp code selects a ramp stop, anything else coasts
    function automatic dss_stop_t dss_stop(input logic [15:0] code);
        if (code == `DSS_OPT_RAMP) begin
            dss_stop = DSS_STOP_RAMP;
        end else begin
            dss_stop = DSS_STOP_COAST;
        end
    endfunction

    function automatic logic dss_code_ok(input logic [15:0] code);
        dss_code_ok = (code == `DSS_OPT_COAST) || (code == `DSS_OPT_RAMP);
    endfunction

    // state bits 6,5,3,2,1,0; don't-care quick-stop positions drive zero
    function automatic logic [15:0] dss_state_bits(input dss_state_t s);
        dss_state_bits = 16'h0000;
        unique case (s)
            DSS_NOT_READY: begin
                dss_state_bits[`DSS_BIT_SODIS] = 1'b0;
                dss_state_bits[`DSS_BIT_QSTOP] = 1'b0;
                dss_state_bits[`DSS_BIT_FAULT] = 1'b0;
                dss_state_bits[`DSS_BIT_OPEN] = 1'b0;
                dss_state_bits[`DSS_BIT_SWON] = 1'b0;
                dss_state_bits[`DSS_BIT_RTSO] = 1'b0;
            end
            DSS_SO_DISABLED: begin
                dss_state_bits[`DSS_BIT_SODIS] = 1'b1;
                dss_state_bits[`DSS_BIT_QSTOP] = 1'b0;
                dss_state_bits[`DSS_BIT_FAULT] = 1'b0;
                dss_state_bits[`DSS_BIT_OPEN] = 1'b0;
                dss_state_bits[`DSS_BIT_SWON] = 1'b0;
                dss_state_bits[`DSS_BIT_RTSO] = 1'b0;
            end
            DSS_READY: begin
                dss_state_bits[`DSS_BIT_SODIS] = 1'b0;
                dss_state_bits[`DSS_BIT_QSTOP] = 1'b1;
                dss_state_bits[`DSS_BIT_FAULT] = 1'b0;
                dss_state_bits[`DSS_BIT_OPEN] = 1'b0;
                dss_state_bits[`DSS_BIT_SWON] = 1'b0;
                dss_state_bits[`DSS_BIT_RTSO] = 1'b1;
            end
            DSS_SWITCHED_ON: begin
                dss_state_bits[`DSS_BIT_SODIS] = 1'b0;
                dss_state_bits[`DSS_BIT_QSTOP] = 1'b1;
                dss_state_bits[`DSS_BIT_FAULT] = 1'b0;
                dss_state_bits[`DSS_BIT_OPEN] = 1'b0;
                dss_state_bits[`DSS_BIT_SWON] = 1'b1;
                dss_state_bits[`DSS_BIT_RTSO] = 1'b1;
            end
            DSS_OP_ENABLED: begin
                dss_state_bits[`DSS_BIT_SODIS] = 1'b0;
                dss_state_bits[`DSS_BIT_QSTOP] = 1'b1;
                dss_state_bits[`DSS_BIT_FAULT] = 1'b0;
                dss_state_bits[`DSS_BIT_OPEN] = 1'b1;
                dss_state_bits[`DSS_BIT_SWON] = 1'b1;
                dss_state_bits[`DSS_BIT_RTSO] = 1'b1;
            end
            DSS_QSTOP_ACTIVE: begin
                dss_state_bits[`DSS_BIT_SODIS] = 1'b0;
                dss_state_bits[`DSS_BIT_QSTOP] = 1'b0;
                dss_state_bits[`DSS_BIT_FAULT] = 1'b0;
                dss_state_bits[`DSS_BIT_OPEN] = 1'b1;
                dss_state_bits[`DSS_BIT_SWON] = 1'b1;
                dss_state_bits[`DSS_BIT_RTSO] = 1'b1;
            end
            DSS_FAULT_REACT, DSS_FAULT: begin
                dss_state_bits[`DSS_BIT_SODIS] = 1'b0;
                dss_state_bits[`DSS_BIT_QSTOP] = 1'b0;
                dss_state_bits[`DSS_BIT_FAULT] = 1'b1;
                dss_state_bits[`DSS_BIT_OPEN] = 1'b1;
                dss_state_bits[`DSS_BIT_SWON] = 1'b1;
                dss_state_bits[`DSS_BIT_RTSO] = 1'b1;
            end
        endcase
    endfunction

    always_comb begin
        r_nxt = r_r;
        st_bits = 16'h0000;
        vel_abs = dss_abs(vel_demand_in);
        // flags from the drive cross in through two flops
        r_nxt.flag_s1 = {drive_running_flag_in, at_speed_flag_in};
        r_nxt.flag_s2 = r_r.flag_s1;
        r_nxt.auto_bit = control_word_in[`DSS_CW_AUTO];
        st_bits = dss_state_bits(dev_state_in);
        st_bits[`DSS_BIT_VDIS] = volt_disable_cmd_in;
        st_bits[`DSS_BIT_REMOTE] = control_word_enable_setting_in & r_r.auto_bit;
        // quick stop swaps the target source to the running flag
        if (dev_state_in == DSS_QSTOP_ACTIVE) begin
            st_bits[`DSS_BIT_TARGET] = r_r.flag_s2[1];
        end else begin
            st_bits[`DSS_BIT_TARGET] = r_r.flag_s2[0];
        end
        below_min = vel_abs < vel_min_amount_in;
        above_max = vel_abs > vel_max_amount_in;
        st_bits[`DSS_BIT_ILIM] = below_min || above_max;
        r_nxt.status = st_bits;

        // object dictionary access, answered one cycle after the request
        code_ok = dss_code_ok(od_wdata_in);
        r_nxt.ack = od_req_in;
        r_nxt.err = 1'b0;
        r_nxt.rdata = 16'h0000;
        if (od_req_in) begin
            unique case (od_index_in)
                `DSS_IDX_STATUS: begin
                    r_nxt.rdata = r_r.status;
                    r_nxt.err = od_write_in;
                end
                `DSS_IDX_SHUTDOWN: begin
                    r_nxt.rdata = r_r.shutdown_code;
                    if (od_write_in) begin
                        r_nxt.err = !code_ok;
                        if (code_ok) begin
                            r_nxt.shutdown_code = od_wdata_in;
                        end
                    end
                end
                `DSS_IDX_DISABLE_OP: begin
                    r_nxt.rdata = r_r.disable_code;
                    if (od_write_in) begin
                        r_nxt.err = !code_ok;
                        if (code_ok) begin
                            r_nxt.disable_code = od_wdata_in;
                        end
                    end
                end
                default: begin
                    r_nxt.err = 1'b1;
                end
            endcase
        end
    end

    // status has no defined default; it reads zero until the first edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_r <= '{flag_s1: 2'h0,
                     flag_s2: 2'h0,
                     status: 16'h0000,
                     shutdown_code: `DSS_SHUTDOWN_RST,
                     disable_code: `DSS_DISABLE_OP_RST,
                     rdata: 16'h0000,
                     ack: 1'b0,
                     err: 1'b0,
                     auto_bit: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign od_ack_out = r_r.ack;
    assign od_err_out = r_r.err;
    assign od_rdata_out = r_r.rdata;
    assign status_word_out = r_r.status;
    assign drive_control_word_auto_out = r_r.auto_bit;
    // stop modes decode straight from the held option codes
    assign shutdown_stop_mode_out = dss_stop(r_r.shutdown_code);
    assign disable_op_stop_mode_out = dss_stop(r_r.disable_code);
    // both ramp codes use the slow-down ramp, standard ramp, normal voltage
    assign slow_down_ramp_sel_out = (dss_stop(r_r.shutdown_code) == DSS_STOP_RAMP) ||
        (dss_stop(r_r.disable_code) == DSS_STOP_RAMP);
endmodule

// file: dv/dss_assertions.sv
`timescale 1ns/100ps
module dss_chk import dss_pkg::*; (
    input wire logic clk_in, rst_n_in, od_req_in, od_write_in, volt_disable_cmd_in,
    input wire logic control_word_enable_setting_in, od_ack_out, drive_control_word_auto_out,
    input wire logic [15:0] od_index_in, od_wdata_in, status_word_out,
    input wire dss_pkg::dss_state_t dev_state_in,
    input wire dss_pkg::dss_stop_t shutdown_stop_mode_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_ack_latency: assert property (1 |=> od_ack_out == $past(od_req_in)) else $error("ack latency");
    a_rsvd_zero: assert property (status_word_out[15:12] == 4'h0 && status_word_out[8:7] == 2'h0)
        else $error("reserved bits set");
    a_vdis_bit: assert property (1 |=> status_word_out[4] == $past(volt_disable_cmd_in))
        else $error("voltage disabled bit");
    a_remote_bit: assert property (1 |=> status_word_out[9] ==
        ($past(drive_control_word_auto_out) & $past(control_word_enable_setting_in))) else $error("remote bit");
    a_open_pattern: assert property (dev_state_in == DSS_OP_ENABLED |=>
        (status_word_out[6:0] & 7'h6f) == 7'h27) else $error("enabled pattern");
    a_fault_pattern: assert property (dev_state_in inside {DSS_FAULT, DSS_FAULT_REACT} |=>
        !status_word_out[6] && status_word_out[3:0] == 4'hf) else $error("fault pattern");
    a_qstop_pattern: assert property (dev_state_in == DSS_QSTOP_ACTIVE |=>
        (status_word_out[6:0] & 7'h6f) == 7'h07) else $error("quick stop pattern");
    a_sd_ramp: assert property (od_req_in && od_write_in && od_index_in == 16'h605b &&
        od_wdata_in == 16'h0001 |=> shutdown_stop_mode_out == DSS_STOP_RAMP) else $error("shutdown mode");
endmodule
bind dss_top dss_chk u_chk(.*);

// file: dv/dss_master.sv
`timescale 1ns/100ps
module dss_master (
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic err_in,
    input wire logic [15:0] rdata_in,
    output logic req_out,
    output logic write_out,
    output logic [15:0] index_out,
    output logic [15:0] wdata_out
);
    initial begin
        req_out = 0;
        write_out = 0;
        index_out = 16'h0;
        wdata_out = 16'h0;
    end
    // one-cycle request, answer taken while it stands
    task xfer(input logic w, input logic [15:0] i, d, output logic a, output logic [15:0] r, output logic e);
        @(negedge clk_in);
        req_out = 1;
        write_out = w;
        index_out = i;
        wdata_out = d;
        @(negedge clk_in);
        a = ack_in;
        r = rdata_in;
        e = err_in;
        req_out = 0;
        index_out = ~i;
        wdata_out = ~d;
    endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
    import dss_pkg::*;
    logic clk_in = 0, rst_n_in = 0, vdis = 0, en = 0, at_spd = 0, run = 0, a, e, req, wr, ack, err, auto, ramp;
    logic [15:0] idx, wd, rd, sw, r, cw = 16'h0, vmin = 16'h0000, vmax = 16'h0064;
    logic signed [15:0] dem = 16'sh0;
    dss_state_t st = DSS_NOT_READY;
    dss_stop_t sd_m, do_m;
    int num_errors = 0, total_checks = 0, cyc = 0;
    logic [6:0] pat [8] = '{7'h00, 7'h40, 7'h23, 7'h21, 7'h0f, 7'h0f, 7'h27, 7'h07};
    initial forever #4 clk_in = ~clk_in;
    dss_master m(.clk_in, .ack_in(ack), .err_in(err), .rdata_in(rd), .req_out(req), .write_out(wr),
        .index_out(idx), .wdata_out(wd));
    dss_top dut(.clk_in, .rst_n_in, .od_req_in(req), .od_write_in(wr), .od_index_in(idx), .od_wdata_in(wd),
        .od_ack_out(ack), .od_err_out(err), .od_rdata_out(rd), .dev_state_in(st), .volt_disable_cmd_in(vdis),
        .control_word_in(cw), .control_word_enable_setting_in(en), .at_speed_flag_in(at_spd),
        .drive_running_flag_in(run), .vel_demand_in(dem), .vel_min_amount_in(vmin),
        .vel_max_amount_in(vmax), .status_word_out(sw), .drive_control_word_auto_out(auto),
        .shutdown_stop_mode_out(sd_m), .disable_op_stop_mode_out(do_m), .slow_down_ramp_sel_out(ramp));
    task chk(input logic [31:0] s, x, input string n);
        total_checks++;
        if (s !== x) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task t_codes;
        chk(do_m, DSS_STOP_RAMP, "do_mode_rst");
        m.xfer(0, 16'h605b, 16'h0, a, r, e); chk({a, e, r}, 18'h20000, "sd_rst");
        m.xfer(0, 16'h605c, 16'h0, a, r, e); chk({a, e, r}, 18'h20001, "do_rst");
        m.xfer(1, 16'h605b, 16'h1, a, r, e); chk(sd_m, DSS_STOP_RAMP, "sd_mode");
        m.xfer(1, 16'h605c, 16'h0, a, r, e); chk({do_m, ramp}, 3'h1, "do_mode");
        m.xfer(1, 16'h605b, 16'h2, a, r, e); chk({a, e}, 2'h3, "sd_bad");
        m.xfer(0, 16'h605b, 16'h0, a, r, e); chk(r, 16'h1, "sd_kept");
        m.xfer(1, 16'h6041, 16'hffff, a, r, e); chk({a, e}, 2'h3, "sw_wr");
        m.xfer(0, 16'h6000, 16'h0, a, r, e); chk({a, e, r}, 18'h30000, "unmapped");
    endtask
    task t_states;
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_in) st = dss_state_t'(k);
            repeat (2) @(negedge clk_in);
            chk(sw, {9'h0, pat[k]}, "state_pat");
        end
    endtask
    task t_flags;
        @(negedge clk_in) {vdis, en, at_spd, cw[11], dem, st} = {4'hf, -16'sd200, DSS_QSTOP_ACTIVE};
        repeat (4) @(negedge clk_in);
        chk(sw, 16'h0a17, "flags_qs");
        chk(auto, 1, "auto");
        {vdis, dem, st} = {1'b0, 16'sd50, DSS_OP_ENABLED};
        repeat (2) @(negedge clk_in);
        chk(sw, 16'h0627, "flags_op");
        m.xfer(0, 16'h6041, 16'h0, a, r, e); chk({a, e, r}, 18'h20627, "sw_read");
        vmin = 16'h003c;
        repeat (2) @(negedge clk_in);
        chk(sw, 16'h0e27, "flags_min");
    endtask
    always @(posedge clk_in) if (++cyc == 5000) begin
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (12) @(negedge clk_in);
        rst_n_in = 1;
        t_codes;
        t_states;
        t_flags;
        wrap_up;
    end
endmodule
